//--- verilog/board_ctrl_pkg.sv
package board_ctrl_pkg;

  // clock and derived timing
  localparam int SYS_CLK_MHZ       = 125;
  localparam int FILTER_TIME_US    = 1000;
  localparam int FILTER_CYCLES     = FILTER_TIME_US * SYS_CLK_MHZ;
  localparam int RESET_HOLD_MS     = 1000;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * SYS_CLK_MHZ;
  localparam int SETTLE_MARGIN     = 4;   // sync stages plus slack
  localparam int CNT_W             = 32;

  // over-temperature threshold in degrees celsius, signed
  localparam logic signed [7:0] ALERT_TEMP_C = 8'sh50;
  localparam int TEMP_W = 8;

  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] CONTROL_OFS    = 8'h0c;

  // status register fields
  localparam int ST_OVERTEMP = 0;
  localparam int ST_ALERT_EN = 1;
  localparam int ST_EXT_RST  = 2;
  localparam int ST_PATTERN  = 3;
  localparam int ST_FAMILY   = 4;
  localparam int ST_ROUTE485 = 5;
  localparam int ST_TEMP_LSB = 8;

  // interrupt status / mask fields
  localparam int IRQ_W            = 4;
  localparam int IRQ_OVERTEMP_ON  = 0;
  localparam int IRQ_OVERTEMP_OFF = 1;
  localparam int IRQ_EXT_RESET    = 2;
  localparam int IRQ_SW_CHANGE    = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // control register fields
  localparam int CTRL_CAM_RESET = 0;
  localparam logic CTRL_RST     = 1'b0;

  // mode switch positions
  localparam int SW_W          = 4;
  localparam int SW_CAM_FAMILY = 0;
  localparam int SW_CTRL_ROUTE = 1;
  localparam int SW_ALERT_EN   = 2;
  localparam int SW_PATTERN    = 3;
  localparam logic SW_RST_LEVEL     = 1'b0;
  localparam logic EXT_RST_N_LEVEL  = 1'b1;

  // reset sequencer
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_RUN,
    ST_QUALIFY,
    ST_SHUTDOWN
  } seq_state_type;

endpackage : board_ctrl_pkg

//--- verilog/input_glitch_filter.sv
`timescale 1ns/1ns
// two-flop synchroniser followed by a stability filter
module input_glitch_filter #(
  parameter int   FILTER_CYCLES = board_ctrl_pkg::FILTER_CYCLES,
  parameter logic RESET_LEVEL   = 1'b0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_raw,
  output logic      o_level
);

  typedef struct packed {
    logic                             meta;
    logic                             sync;
    logic                             level;
    logic [board_ctrl_pkg::CNT_W-1:0] cnt;
  } filt_state_type;

  localparam logic [board_ctrl_pkg::CNT_W-1:0] CNT_LAST =
    board_ctrl_pkg::CNT_W'(FILTER_CYCLES - 1);

  filt_state_type s_reg;
  filt_state_type s_next;

  // level moves only after the synced input held steady long enough
  always_comb begin
    s_next      = s_reg;
    s_next.meta = i_raw;
    s_next.sync = s_reg.meta;  // meta feeds nothing else
    if (s_reg.sync == s_reg.level) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == CNT_LAST) begin
      s_next.level = s_reg.sync;
      s_next.cnt   = '0;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg       <= '0;
      s_reg.meta  <= RESET_LEVEL;
      s_reg.sync  <= RESET_LEVEL;
      s_reg.level <= RESET_LEVEL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_level = s_reg.level;

endmodule : input_glitch_filter

//--- verilog/board_mode_alert_reset_ctrl.sv
`timescale 1ns/1ns
module board_mode_alert_reset_ctrl #(
  parameter int FILTER_CYCLES     = board_ctrl_pkg::FILTER_CYCLES,
  parameter int RESET_HOLD_CYCLES = board_ctrl_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_sys_rst,
  input  wire logic [board_ctrl_pkg::SW_W-1:0]   i_mode_sw,
  input  wire logic                              i_ext_reset_n,
  input  wire logic [board_ctrl_pkg::TEMP_W-1:0] i_board_temp,
  input  wire logic                              i_host_ttl_rx,
  input  wire logic                              i_host_232_rx,
  input  wire logic                              i_host_485_rx,
  input  wire logic                              i_cam_tx,
  input  wire logic                              i_psel,
  input  wire logic                              i_penable,
  input  wire logic                              i_pwrite,
  input  wire logic [board_ctrl_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [board_ctrl_pkg::DATA_W-1:0] i_pwdata,
  output logic [board_ctrl_pkg::DATA_W-1:0]      o_prdata,
  output logic                                   o_pready,
  output logic                                   o_pslverr,
  output logic                                   o_host_ttl_tx,
  output logic                                   o_host_232_tx,
  output logic                                   o_host_485_tx,
  output logic                                   o_cam_rx,
  output logic                                   o_cam_family_sel,
  output logic                                   o_pattern_source_sel,
  output logic                                   o_cam_reset_n,
  output logic                                   o_core_reset,
  output logic                                   o_alert_led,
  output logic                                   o_irq
);

  localparam int CW = board_ctrl_pkg::CNT_W;
  localparam logic [CW-1:0] SETTLE_LAST =
    CW'(FILTER_CYCLES + board_ctrl_pkg::SETTLE_MARGIN - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(RESET_HOLD_CYCLES - 1);

  typedef struct packed {
    board_ctrl_pkg::seq_state_type          seq;
    logic [CW-1:0]                          cnt;
    logic                                   pattern_taken;
    logic                                   pattern_sel;
    logic                                   family;
    logic                                   route485;
    logic                                   alert_en;
    logic                                   over_temp;
    logic                                   led;
    logic [board_ctrl_pkg::TEMP_W-1:0]      temp;
    logic [board_ctrl_pkg::SW_W-1:0]        sw_prev;
    logic [board_ctrl_pkg::IRQ_W-1:0]       irq_status;
    logic [board_ctrl_pkg::IRQ_W-1:0]       irq_mask;
    logic                                   ctrl_cam_reset;
    logic                                   host_ttl_tx;
    logic                                   host_232_tx;
    logic                                   host_485_tx;
    logic                                   cam_rx;
    logic                                   cam_reset_n;
    logic                                   core_reset;
    logic                                   irq;
    logic [board_ctrl_pkg::DATA_W-1:0]      prdata;
    logic                                   pready;
    logic                                   pslverr;
  } ctrl_state_type;

  ctrl_state_type s_reg;
  ctrl_state_type s_next;

  logic [board_ctrl_pkg::SW_W-1:0] sw_level;
  logic                            ext_rst_n_level;

  // one register per mapped offset; anything else is an error
  function automatic logic reg_hit(
    input logic [board_ctrl_pkg::ADDR_W-1:0] addr
  );
    reg_hit = (addr == board_ctrl_pkg::STATUS_OFS)     ||
              (addr == board_ctrl_pkg::IRQ_STATUS_OFS) ||
              (addr == board_ctrl_pkg::IRQ_MASK_OFS)   ||
              (addr == board_ctrl_pkg::CONTROL_OFS);
  endfunction : reg_hit

  // signed compare against the alert threshold
  function automatic logic temp_over(
    input logic [board_ctrl_pkg::TEMP_W-1:0] t,
    input logic                              or_equal
  );
    logic signed [board_ctrl_pkg::TEMP_W-1:0] st;
    st = signed'(t);
    temp_over = or_equal ? (st >= board_ctrl_pkg::ALERT_TEMP_C)
                         : (st >  board_ctrl_pkg::ALERT_TEMP_C);
  endfunction : temp_over

  // switches and reset line filtered before use
  genvar gi;
  generate
    for (gi = 0; gi < board_ctrl_pkg::SW_W; gi = gi + 1) begin : g_sw
      input_glitch_filter #(
        .FILTER_CYCLES (FILTER_CYCLES),
        .RESET_LEVEL   (board_ctrl_pkg::SW_RST_LEVEL)
      ) u_sw_filter (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_raw     (i_mode_sw[gi]),
        .o_level   (sw_level[gi])
      );
    end
  endgenerate

  input_glitch_filter #(
    .FILTER_CYCLES (FILTER_CYCLES),
    .RESET_LEVEL   (board_ctrl_pkg::EXT_RST_N_LEVEL)
  ) u_rst_filter (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_raw     (i_ext_reset_n),
    .o_level   (ext_rst_n_level)
  );

  // next state of the whole block
  always_comb begin
    logic                              access;
    logic                              ext_accept;
    logic [board_ctrl_pkg::DATA_W-1:0] rd;
    logic [board_ctrl_pkg::IRQ_W-1:0]  ev;
    access     = i_psel && i_penable;
    ext_accept = 1'b0;
    rd         = '0;
    ev         = '0;
    s_next     = s_reg;

    // live switch settings
    s_next.family   = sw_level[board_ctrl_pkg::SW_CAM_FAMILY];
    s_next.route485 = sw_level[board_ctrl_pkg::SW_CTRL_ROUTE];
    s_next.alert_en = sw_level[board_ctrl_pkg::SW_ALERT_EN];
    s_next.sw_prev  = sw_level;

    // temperature: led on strictly above, pin alert at or above
    s_next.temp      = i_board_temp;
    s_next.led       = temp_over(i_board_temp, 1'b0);
    s_next.over_temp = temp_over(i_board_temp, 1'b1);

    // reset sequencer
    case (s_reg.seq)
      board_ctrl_pkg::ST_POWERUP: begin
        // wait until filters have seen the real switch levels
        if (s_reg.cnt == SETTLE_LAST) begin
          s_next.cnt = '0;
          s_next.seq = board_ctrl_pkg::ST_RUN;
          if (!s_reg.pattern_taken) begin
            s_next.pattern_sel   = sw_level[board_ctrl_pkg::SW_PATTERN];
            s_next.pattern_taken = 1'b1;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 32'h1;
        end
      end
      board_ctrl_pkg::ST_RUN: begin
        s_next.cnt = '0;
        if (!ext_rst_n_level) begin
          s_next.seq = board_ctrl_pkg::ST_QUALIFY;
        end
      end
      board_ctrl_pkg::ST_QUALIFY: begin
        // short low pulses fall back without effect
        if (ext_rst_n_level) begin
          s_next.seq = board_ctrl_pkg::ST_RUN;
          s_next.cnt = '0;
        end else if (s_reg.cnt == HOLD_LAST) begin
          s_next.seq = board_ctrl_pkg::ST_SHUTDOWN;
          s_next.cnt = '0;
          ext_accept = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 32'h1;
        end
      end
      board_ctrl_pkg::ST_SHUTDOWN: begin
        // held down as long as the line stays low, then restart
        s_next.cnt = '0;
        if (ext_rst_n_level) begin
          s_next.seq = board_ctrl_pkg::ST_POWERUP;
        end
      end
      default: begin
        s_next.seq = board_ctrl_pkg::ST_POWERUP;
        s_next.cnt = '0;
      end
    endcase

    // apb: setup, one wait cycle, then completion
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.prdata  = '0;
    if (access && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !reg_hit(i_paddr);
      rd[board_ctrl_pkg::ST_OVERTEMP] = s_reg.over_temp;
      rd[board_ctrl_pkg::ST_ALERT_EN] = s_reg.alert_en;
      rd[board_ctrl_pkg::ST_EXT_RST]  =
        (s_reg.seq == board_ctrl_pkg::ST_SHUTDOWN);
      rd[board_ctrl_pkg::ST_PATTERN]  = s_reg.pattern_sel;
      rd[board_ctrl_pkg::ST_FAMILY]   = s_reg.family;
      rd[board_ctrl_pkg::ST_ROUTE485] = s_reg.route485;
      rd[board_ctrl_pkg::ST_TEMP_LSB +: board_ctrl_pkg::TEMP_W] =
        s_reg.temp;
      if (!i_pwrite) begin
        case (i_paddr)
          board_ctrl_pkg::STATUS_OFS:     s_next.prdata = rd;
          board_ctrl_pkg::IRQ_STATUS_OFS: s_next.prdata =
            {28'h0, s_reg.irq_status};
          board_ctrl_pkg::IRQ_MASK_OFS:   s_next.prdata =
            {28'h0, s_reg.irq_mask};
          board_ctrl_pkg::CONTROL_OFS:    s_next.prdata =
            {31'h0, s_reg.ctrl_cam_reset};
          default:                        s_next.prdata = '0;
        endcase
      end
    end else if (access && s_reg.pready) begin
      // the completing edge: writes land, read of irq status clears it
      if (i_pwrite) begin
        if (i_paddr == board_ctrl_pkg::IRQ_MASK_OFS) begin
          s_next.irq_mask = i_pwdata[board_ctrl_pkg::IRQ_W-1:0];
        end
        if (i_paddr == board_ctrl_pkg::CONTROL_OFS) begin
          s_next.ctrl_cam_reset = i_pwdata[board_ctrl_pkg::CTRL_CAM_RESET];
        end
      end else if (i_paddr == board_ctrl_pkg::IRQ_STATUS_OFS) begin
        s_next.irq_status = '0;
      end
    end

    // a line reset also returns software settings to defaults
    if (ext_accept) begin
      s_next.irq_mask       = board_ctrl_pkg::IRQ_MASK_RST;
      s_next.ctrl_cam_reset = board_ctrl_pkg::CTRL_RST;
    end

    // events are applied after the clear so a same-cycle set wins
    ev[board_ctrl_pkg::IRQ_OVERTEMP_ON]  = s_next.over_temp &&
                                           !s_reg.over_temp;
    ev[board_ctrl_pkg::IRQ_OVERTEMP_OFF] = !s_next.over_temp &&
                                           s_reg.over_temp;
    ev[board_ctrl_pkg::IRQ_EXT_RESET]    = ext_accept;
    ev[board_ctrl_pkg::IRQ_SW_CHANGE]    = (sw_level != s_reg.sw_prev) &&
      (s_reg.seq != board_ctrl_pkg::ST_POWERUP);
    s_next.irq_status = s_next.irq_status | ev;
    s_next.irq        = |(s_reg.irq_status & s_reg.irq_mask);

    // serial routing; rx lines idle high so and-ing is safe
    if (s_reg.route485) begin
      s_next.cam_rx      = i_host_485_rx;
      s_next.host_485_tx = i_cam_tx;
      s_next.host_232_tx = 1'b1;
      s_next.host_ttl_tx = 1'b1;
    end else begin
      s_next.cam_rx      = i_host_ttl_rx & i_host_232_rx;
      s_next.host_485_tx = 1'b1;
      s_next.host_232_tx = i_cam_tx;
      s_next.host_ttl_tx = i_cam_tx;
    end
    if (s_reg.alert_en) begin
      s_next.host_ttl_tx = !s_reg.over_temp;
    end

    // camera reset low during power-up, shutdown or software request
    s_next.cam_reset_n = !((s_reg.seq == board_ctrl_pkg::ST_POWERUP) ||
                           (s_reg.seq == board_ctrl_pkg::ST_SHUTDOWN) ||
                           s_reg.ctrl_cam_reset);
    s_next.core_reset  = (s_reg.seq == board_ctrl_pkg::ST_SHUTDOWN);
  end

  // single state register; idle-high lines start high
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg             <= '0;
      s_reg.seq         <= board_ctrl_pkg::ST_POWERUP;
      s_reg.irq_mask    <= board_ctrl_pkg::IRQ_MASK_RST;
      s_reg.host_ttl_tx <= 1'b1;
      s_reg.host_232_tx <= 1'b1;
      s_reg.host_485_tx <= 1'b1;
      s_reg.cam_rx      <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_prdata             = s_reg.prdata;
  assign o_pready             = s_reg.pready;
  assign o_pslverr            = s_reg.pslverr;
  assign o_host_ttl_tx        = s_reg.host_ttl_tx;
  assign o_host_232_tx        = s_reg.host_232_tx;
  assign o_host_485_tx        = s_reg.host_485_tx;
  assign o_cam_rx             = s_reg.cam_rx;
  assign o_cam_family_sel     = s_reg.family;
  assign o_pattern_source_sel = s_reg.pattern_sel;
  assign o_cam_reset_n        = s_reg.cam_reset_n;
  assign o_core_reset         = s_reg.core_reset;
  assign o_alert_led          = s_reg.led;
  assign o_irq                = s_reg.irq;

  // checks on the driven outputs
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_alert_pin_low: assert property (
    s_reg.alert_en && s_reg.over_temp |=> !o_host_ttl_tx
  ) else $error("alert pin not low while hot");

  a_alert_pin_high: assert property (
    s_reg.alert_en && !s_reg.over_temp |=> o_host_ttl_tx
  ) else $error("alert pin not high while cool");

  a_led_threshold: assert property (
    temp_over(i_board_temp, 1'b0) |=> o_alert_led ##1 1'b1
  ) else $error("led off above threshold");

  a_tx_pass_data: assert property (
    !s_reg.alert_en && !s_reg.route485 |=>
      o_host_ttl_tx == $past(i_cam_tx)
  ) else $error("shared pin not carrying transmit data");

  a_route_485: assert property (
    s_reg.route485 |=> o_host_485_tx == $past(i_cam_tx) &&
      o_cam_rx == $past(i_host_485_rx) && o_host_232_tx
  ) else $error("differential route wrong");

  a_family_follow: assert property (
    ##1 o_cam_family_sel == $past(sw_level[board_ctrl_pkg::SW_CAM_FAMILY])
  ) else $error("family select does not follow switch");

  a_pattern_frozen: assert property (
    s_reg.pattern_taken |=> $stable(o_pattern_source_sel)
  ) else $error("pattern select changed after power-up");

  a_shutdown_reset: assert property (
    s_reg.seq == board_ctrl_pkg::ST_SHUTDOWN |=>
      !o_cam_reset_n && o_core_reset
  ) else $error("camera not held in reset during shutdown");

  a_short_pulse: assert property (
    s_reg.seq == board_ctrl_pkg::ST_QUALIFY && ext_rst_n_level |=>
      s_reg.seq == board_ctrl_pkg::ST_RUN ##1 o_cam_reset_n ||
      s_reg.ctrl_cam_reset
  ) else $error("short reset pulse was accepted");

  a_irq_level: assert property (
    |(s_reg.irq_status & s_reg.irq_mask) |=> o_irq
  ) else $error("irq low with unmasked status");

endmodule : board_mode_alert_reset_ctrl

//--- testbench/host_line_model.sv
`timescale 1ns/1ns
// host side of the control connector: reset line and serial receive lines
module host_line_model (
  input  wire logic i_sys_clk,
  output logic      o_ext_reset_n,
  output logic      o_ttl_rx,
  output logic      o_232_rx,
  output logic      o_485_rx
);
  // every line idles high until the bench asks otherwise
  initial begin
    o_ext_reset_n = 1'b1;
    o_ttl_rx      = 1'b1;
    o_232_rx      = 1'b1;
    o_485_rx      = 1'b1;
  end

  // pull the line low for a count of clocks; short pulses are no reset
  task automatic hold_reset(input int cycles);
    @(posedge i_sys_clk);
    o_ext_reset_n <= 1'b0;
    repeat (cycles) @(posedge i_sys_clk);
    o_ext_reset_n <= 1'b1;
  endtask : hold_reset

  // only one single-ended port carries data, the other stays idle high
  task automatic send(input logic diff, input logic v);
    if (diff) begin
      o_485_rx <= v;
    end else begin
      o_ttl_rx <= v;
    end
  endtask : send
endmodule : host_line_model

//--- testbench/test_board_mode_alert_reset_ctrl.sv
`timescale 1ns/1ns
module test_board_mode_alert_reset_ctrl;
  localparam int FILT = 4;
  localparam int HOLD = 20;
  logic        i_sys_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [3:0]  sw        = 4'h8;
  logic [7:0]  temp      = 8'h19;
  logic        cam_tx    = 1'b1;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err;
  logic        ext_rst_n, ttl_rx, r232_rx, r485_rx;
  logic        ttl_tx, tx232, tx485, cam_rx, fam, pat;
  logic        cam_rst_n, core_rst, led, irq;
  logic [7:0]  tv [4] = '{8'h4f, 8'h50, 8'h51, 8'hf6};
  int          mismatches  = 0;
  int          comparisons = 0;

  // free-running system clock
  always #4 i_sys_clk = ~i_sys_clk;

  host_line_model u_host (
    .i_sys_clk    (i_sys_clk),
    .o_ext_reset_n(ext_rst_n),
    .o_ttl_rx     (ttl_rx),
    .o_232_rx     (r232_rx),
    .o_485_rx     (r485_rx)
  );

  board_mode_alert_reset_ctrl #(
    .FILTER_CYCLES    (FILT),
    .RESET_HOLD_CYCLES(HOLD)
  ) u_dut (
    .i_sys_clk           (i_sys_clk),
    .i_sys_rst           (i_sys_rst),
    .i_mode_sw           (sw),
    .i_ext_reset_n       (ext_rst_n),
    .i_board_temp        (temp),
    .i_host_ttl_rx       (ttl_rx),
    .i_host_232_rx       (r232_rx),
    .i_host_485_rx       (r485_rx),
    .i_cam_tx            (cam_tx),
    .i_psel              (psel),
    .i_penable           (pen),
    .i_pwrite            (pwr),
    .i_paddr             (paddr),
    .i_pwdata            (pwdata),
    .o_prdata            (prdata),
    .o_pready            (pready),
    .o_pslverr           (pslverr),
    .o_host_ttl_tx       (ttl_tx),
    .o_host_232_tx       (tx232),
    .o_host_485_tx       (tx485),
    .o_cam_rx            (cam_rx),
    .o_cam_family_sel    (fam),
    .o_pattern_source_sel(pat),
    .o_cam_reset_n       (cam_rst_n),
    .o_core_reset        (core_rst),
    .o_alert_led         (led),
    .o_irq               (irq)
  );

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick

  // outputs read in the active region hold the values sampled at the edge
  task automatic wait_cam(input logic lvl);
    int n;
    for (n = 0; n < 60 && cam_rst_n !== lvl; n++) tick(1);
    if (n >= 60) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_cam

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_sys_clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
  endtask : apb

  initial begin
    int i;
    tick(20);
    i_sys_rst <= 1'b0;
    tick(2);
    check(cam_rst_n, 1'b0);
    wait_cam(1'b1);
    check(pat, 1'b1);
    // family on, pattern switch off; pattern must not follow
    sw <= 4'h1;
    tick(FILT + 8);
    check(fam, 1'b1);
    check(pat, 1'b1);
    // one-cycle glitch on the family switch is filtered out
    sw <= 4'h0;
    tick(1);
    sw <= 4'h1;
    repeat (FILT + 8) begin
      tick(1);
      check(fam, 1'b1);
    end
    // pass-through on both routes, single-ended first
    for (i = 0; i < 4; i++) begin
      if (i == 2) begin
        sw <= 4'h3;
        tick(FILT + 8);
      end
      cam_tx <= i[0];
      u_host.send(i[1], i[0]);
      tick(3);
      check(cam_rx, i[0]);
      check(i[1] ? tx485 : tx232, i[0]);
      if (i < 2) check(ttl_tx, i[0]);
    end
    // alert on: shared pin shows temperature, not camera data
    sw <= 4'h5;
    cam_tx <= 1'b0;
    tick(FILT + 8);
    for (i = 0; i < 4; i++) begin
      temp <= tv[i];
      tick(3);
      check(ttl_tx, $signed(tv[i]) < board_ctrl_pkg::ALERT_TEMP_C);
      check(led, $signed(tv[i]) > board_ctrl_pkg::ALERT_TEMP_C);
    end
    // interrupt masked, then raised and cleared by reading
    check(irq, 1'b0);
    apb(1'b1, board_ctrl_pkg::IRQ_MASK_OFS, 32'hff);
    apb(1'b0, board_ctrl_pkg::IRQ_MASK_OFS, 32'h0);
    check(rd, 32'h0f);
    apb(1'b1, board_ctrl_pkg::IRQ_MASK_OFS, 32'h1);
    apb(1'b0, board_ctrl_pkg::IRQ_STATUS_OFS, 32'h0);
    tick(3);
    check(irq, 1'b0);
    temp <= 8'h50;
    tick(5);
    check(irq, 1'b1);
    apb(1'b0, board_ctrl_pkg::STATUS_OFS, 32'h0);
    check(rd & 32'hff03, 32'h5003);
    apb(1'b0, board_ctrl_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rd[0], 1'b1);
    tick(3);
    check(irq, 1'b0);
    apb(1'b1, board_ctrl_pkg::STATUS_OFS, 32'h0);
    check(err, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
    // software camera reset pulls the camera line low, core untouched
    apb(1'b1, board_ctrl_pkg::CONTROL_OFS, 32'h1);
    apb(1'b0, board_ctrl_pkg::CONTROL_OFS, 32'h0);
    check(rd, 32'h1);
    check({core_rst, cam_rst_n}, 2'b00);
    apb(1'b1, board_ctrl_pkg::CONTROL_OFS, 32'h0);
    tick(2);
    check({core_rst, cam_rst_n}, 2'b01);
    // short low pulse on the reset line is ignored, watched every cycle
    u_host.hold_reset(10);
    repeat (FILT + HOLD + 10) begin
      tick(1);
      check({core_rst, cam_rst_n}, 2'b01);
    end
    // a long low resets the core and the camera
    u_host.hold_reset(FILT + HOLD + 20);
    check({core_rst, cam_rst_n}, 2'b10);
    wait_cam(1'b1);
    check(pat, 1'b1);
    apb(1'b0, board_ctrl_pkg::IRQ_MASK_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, board_ctrl_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rd[board_ctrl_pkg::IRQ_EXT_RESET], 1'b1);
    // power cycle: the pattern switch, now off, is taken afresh
    i_sys_rst <= 1'b1;
    tick(20);
    i_sys_rst <= 1'b0;
    wait_cam(1'b1);
    check(pat, 1'b0);
    complete_run();
  end
endmodule : test_board_mode_alert_reset_ctrl
